// File: logic/fsgp_host.sv
// host controller driving flash strobes for command writes and group protection
//
// Functional notes
// [RQ1] device splits 2 MB into 32 sectors of 64 KB by top five address bits
// [RQ2] device forms eight groups of four sectors chosen by top three address bits
// [RQ3] command write only with strobe low, select low, gate high; host drives exactly that
// [RQ4] command register maps to no array address and never alters array directly
// [RQ5] device latches address on the later falling edge of strobe or select
// [RQ6] device latches data on the later rising edge of strobe or select
// [RQ7] latched command contents feed the device state machine choosing operation
// [RQ8] device blocks program and erase in any combination of protected groups
// [RQ9] device ships with every group unprotected
// [RQ10] host protects with high voltage on id pin and gate, select low, group on top bits
// [RQ11] protection programming runs from strobe falling edge to its rising edge
// [RQ12] host keeps group address unchanged while the protect pulse is low
// [RQ13] check mode returns 01h for protected group, 00h otherwise
// [RQ14] check needs high voltage id pin, select and gate low, strobe high, bits 0,1,0
// [RQ15] identification addresses with address line one low return id bytes
// [RQ16] after in-system id command, read at XX02h gives bit zero for protected group
// [RQ17] device unprotects while reset pin is elevated, reprotects when removed
// [RQ18] device drops a bad command sequence and returns to array read
// [RQ19] program or erase aimed at a protected group leaves it unchanged
`timescale 1ns/100ps
`include "fsgp_map.svh"
module fsgp_host
  import fsgp_pkg::*;
#(
  parameter int PROT_PULSE_CYC = `FSGP_CYC(`FSGP_PROT_PULSE_NS)
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fsgp_op_t cmd_op,
  input wire logic [`FSGP_ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic unprotect_req,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_protected,
  output logic [`FSGP_ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  output logic flash_chip_sel_n,
  output logic flash_out_gate_n,
  output logic flash_write_strobe_n,
  output logic flash_id_pin_hv,
  output logic flash_out_gate_hv,
  output logic flash_reset_hv
);
  localparam logic [15:0] SETUP_CYC = 16'(`FSGP_CYC(`FSGP_SETUP_NS));
  localparam logic [15:0] WE_CYC = 16'(`FSGP_CYC(`FSGP_WE_PULSE_NS));
  localparam logic [15:0] HOLD_CYC = 16'(`FSGP_CYC(`FSGP_HOLD_NS));
  localparam logic [15:0] READ_CYC = 16'(`FSGP_CYC(`FSGP_ACCESS_NS) + `FSGP_SYNC_CYC);
  localparam logic [15:0] PROT_CYC = 16'(PROT_PULSE_CYC);

  function automatic logic [2:0] group_of(input logic [`FSGP_ADDR_W-1:0] a);
    return a[`FSGP_ADDR_W-1:`FSGP_GRP_LO];
  endfunction

  function automatic logic is_write_op(input fsgp_op_t op);
    return (op == FSGP_OP_WRITE) || (op == FSGP_OP_PROTECT);
  endfunction

  fsgp_tmr_if tmr_bus ();
  fsgp_phase_tmr u_tmr (.clock(clock), .reset(reset), .t(tmr_bus));

  fsgp_state_t state_reg, state_next;
  fsgp_op_t op_reg, op_next;
  logic [`FSGP_ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] dout_reg, dout_next;
  logic cs_n_reg, cs_n_next;
  logic og_n_reg, og_n_next;
  logic we_n_reg, we_n_next;
  logic oe_n_reg, oe_n_next;
  logic a9_hv_reg, a9_hv_next;
  logic og_hv_reg, og_hv_next;
  logic ready_reg, ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic rsp_prot_reg, rsp_prot_next;
  logic unprot_reg, unprot_next;
  logic [7:0] dq_s1_reg, dq_s2_reg;

  // two-stage catch of the data pins
  always_ff @(posedge clock) begin
    if (reset) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= flash_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    cs_n_next = cs_n_reg;
    og_n_next = og_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    a9_hv_next = a9_hv_reg;
    og_hv_next = og_hv_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    rsp_prot_next = rsp_prot_reg;
    unprot_next = unprotect_req;
    tmr_bus.load = 1'b0;
    tmr_bus.count = 16'h0000;
    unique case (state_reg)
      FSGP_ST_IDLE: begin
        if (cmd_valid && ready_reg) begin
          op_next = cmd_op;
          addr_next = cmd_addr;
          dout_next = cmd_data;
          cs_n_next = 1'b0;
          ready_next = 1'b0;
          og_n_next = is_write_op(cmd_op); // see [RQ3]
          oe_n_next = (cmd_op != FSGP_OP_WRITE);
          if (cmd_op == FSGP_OP_PROTECT) begin
            a9_hv_next = 1'b1; // see [RQ10]
            og_hv_next = 1'b1;
          end
          if (cmd_op == FSGP_OP_VERIFY) begin
            // line one high keeps the id bytes off the bus, see [RQ15]
            a9_hv_next = 1'b1; // see [RQ14]
            addr_next[`FSGP_VSEL_HIGH_BIT] = 1'b0;
            addr_next[`FSGP_VSEL_MID_BIT] = 1'b1;
            addr_next[`FSGP_VSEL_LOW_BIT] = 1'b0;
          end
          tmr_bus.load = 1'b1;
          tmr_bus.count = SETUP_CYC;
          state_next = FSGP_ST_SETUP;
        end
      end
      FSGP_ST_SETUP: begin
        if (tmr_bus.done) begin
          tmr_bus.load = 1'b1;
          if (is_write_op(op_reg)) begin
            // strobe falls after select, so address is taken here, see [RQ5] [RQ11]
            we_n_next = 1'b0;
            tmr_bus.count = (op_reg == FSGP_OP_PROTECT) ? PROT_CYC : WE_CYC;
          end else begin
            tmr_bus.count = READ_CYC;
          end
          state_next = FSGP_ST_ACTIVE;
        end
      end
      FSGP_ST_ACTIVE: begin
        if (tmr_bus.done) begin
          if (is_write_op(op_reg)) begin
            // strobe rises first, ending the protect pulse, see [RQ11]
            we_n_next = 1'b1;
          end else begin
            rsp_data_next = dq_s2_reg;
            rsp_prot_next = dq_s2_reg[0]; // see [RQ13] [RQ16]
            og_n_next = 1'b1;
          end
          tmr_bus.load = 1'b1;
          tmr_bus.count = HOLD_CYC;
          state_next = FSGP_ST_HOLD;
        end
      end
      FSGP_ST_HOLD: begin
        if (tmr_bus.done) begin
          // select rises last, so the device takes data here, see [RQ6]
          cs_n_next = 1'b1;
          og_n_next = 1'b1;
          a9_hv_next = 1'b0;
          og_hv_next = 1'b0;
          rsp_valid_next = !is_write_op(op_reg);
          state_next = FSGP_ST_DONE;
        end
      end
      FSGP_ST_DONE: begin
        ready_next = 1'b1;
        // data stays driven one cycle past the select rise
        oe_n_next = 1'b1;
        state_next = FSGP_ST_IDLE;
      end
      default: begin
        state_next = FSGP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= FSGP_ST_IDLE;
      op_reg <= FSGP_OP_WRITE;
      addr_reg <= '0;
      dout_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      og_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      a9_hv_reg <= 1'b0;
      og_hv_reg <= 1'b0;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_prot_reg <= 1'b0;
      unprot_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      cs_n_reg <= cs_n_next;
      og_n_reg <= og_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      a9_hv_reg <= a9_hv_next;
      og_hv_reg <= og_hv_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_prot_reg <= rsp_prot_next;
      unprot_reg <= unprot_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_protected = rsp_prot_reg;
  assign flash_addr = addr_reg;
  assign flash_dq_out = dout_reg;
  assign flash_dq_oe_n = oe_n_reg;
  assign flash_chip_sel_n = cs_n_reg;
  assign flash_out_gate_n = og_n_reg;
  assign flash_write_strobe_n = we_n_reg;
  assign flash_id_pin_hv = a9_hv_reg;
  assign flash_out_gate_hv = og_hv_reg;
  assign flash_reset_hv = unprot_reg; // see [RQ17]

  // helper: length of the current strobe low phase
  logic [15:0] we_low_cnt;
  always_ff @(posedge clock) begin
    if (reset || we_n_reg) begin
      we_low_cnt <= 16'h0000;
    end else begin
      we_low_cnt <= we_low_cnt + 16'h0001;
    end
  end

  a_write_combo: assert property (@(posedge clock) disable iff (reset) // see [RQ3]
    !we_n_reg && (op_reg == FSGP_OP_WRITE) |-> !cs_n_reg && og_n_reg && !og_hv_reg && !a9_hv_reg)
    else $error("command write with wrong strobe combination");

  a_protect_levels: assert property (@(posedge clock) disable iff (reset) // see [RQ10]
    !we_n_reg && (op_reg == FSGP_OP_PROTECT) |-> a9_hv_reg && og_hv_reg && !cs_n_reg)
    else $error("protect pulse without high voltage setup");

  a_group_held: assert property (@(posedge clock) disable iff (reset) // see [RQ12]
    !we_n_reg && !$past(we_n_reg) |-> group_of(addr_reg) == group_of($past(addr_reg)))
    else $error("group address moved during strobe low");

  a_verify_levels: assert property (@(posedge clock) disable iff (reset) // see [RQ14]
    (state_reg == FSGP_ST_ACTIVE) && (op_reg == FSGP_OP_VERIFY) |->
      a9_hv_reg && !cs_n_reg && !og_n_reg && we_n_reg &&
      !addr_reg[`FSGP_VSEL_HIGH_BIT] && addr_reg[`FSGP_VSEL_MID_BIT] &&
      !addr_reg[`FSGP_VSEL_LOW_BIT])
    else $error("verify read with wrong pin levels");

  a_pulse_length: assert property (@(posedge clock) disable iff (reset) // see [RQ11]
    $rose(we_n_reg) |-> $past(we_low_cnt) == (($past(op_reg) == FSGP_OP_PROTECT) ?
      PROT_CYC : WE_CYC))
    else $error("strobe low phase has wrong length");

  a_select_brackets: assert property (@(posedge clock) disable iff (reset) // see [RQ5] [RQ6]
    (!we_n_reg || $rose(we_n_reg)) |-> !cs_n_reg && !$past(cs_n_reg))
    else $error("select does not bracket the strobe");

  a_rsp_sample: assert property (@(posedge clock) disable iff (reset) // see [RQ13]
    rsp_valid_reg |-> rsp_protected == rsp_data_reg[0] && $past(cs_n_reg) == 1'b0)
    else $error("response bit does not follow sampled data");
endmodule

// File: logic/fsgp_map.svh
// timing counts, address fields and codes for the flash group-protect host
`ifndef FSGP_MAP_SVH
`define FSGP_MAP_SVH

`define FSGP_CLK_NS 50
`define FSGP_SETUP_NS 50
`define FSGP_WE_PULSE_NS 100
`define FSGP_HOLD_NS 50
`define FSGP_ACCESS_NS 150
`define FSGP_PROT_PULSE_NS 100000
`define FSGP_CYC(ns) (((ns) + `FSGP_CLK_NS - 1) / `FSGP_CLK_NS)
`define FSGP_SYNC_CYC 2

`define FSGP_ADDR_W 21
`define FSGP_SECT_LO 16
`define FSGP_GRP_LO 18
`define FSGP_ID_PIN_BIT 9
`define FSGP_VSEL_HIGH_BIT 6
`define FSGP_VSEL_MID_BIT 1
`define FSGP_VSEL_LOW_BIT 0
`define FSGP_CHECK_LOW_BYTE 8'h02
`define FSGP_PROT_CODE 8'h01

`endif

// File: logic/fsgp_pkg.sv
// types for the flash group-protect host
package fsgp_pkg;
  typedef enum logic [1:0] {
    FSGP_OP_WRITE = 2'h0,
    FSGP_OP_READ = 2'h1,
    FSGP_OP_PROTECT = 2'h2,
    FSGP_OP_VERIFY = 2'h3
  } fsgp_op_t;

  typedef enum logic [2:0] {
    FSGP_ST_IDLE = 3'h0,
    FSGP_ST_SETUP = 3'h1,
    FSGP_ST_ACTIVE = 3'h3,
    FSGP_ST_HOLD = 3'h2,
    FSGP_ST_DONE = 3'h6
  } fsgp_state_t;
endpackage

// File: logic/fsgp_tmr_if.sv
// load and done handshake between the sequencer and its phase timer
`timescale 1ns/100ps
interface fsgp_tmr_if;
  logic load;
  logic [15:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// File: logic/fsgp_phase_tmr.sv
// down counter timing each pin phase
`timescale 1ns/100ps
module fsgp_phase_tmr
  import fsgp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  fsgp_tmr_if.tmr t
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (t.load) begin
      cnt_next = t.count;
    end else if (cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // done must not look at load: the sequencer raises load from done
  assign t.done = (cnt_reg == 16'h0000);

  a_timer_counts: assert property (@(posedge clock) disable iff (reset)
    t.load && (t.count == 16'h0002) |=> !t.done ##1 !t.done ##1 t.done)
    else $error("phase timer length wrong");
endmodule

// File: dv/fsgp_flash_model.sv
// behavioural flash device answering the host pins
`timescale 1ns/100ps
module fsgp_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3c // arbitrary value
) (
  input wire logic [20:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_strobe_n,
  input wire logic id_pin_hv,
  input wire logic out_gate_hv,
  input wire logic reset_hv
);
  logic [7:0] mem [logic [20:0]];
  logic [7:0] prot = 8'h00;
  logic [20:0] a_lat = '0;
  logic [7:0] last = 8'h00;
  logic [7:0] q = 8'hff;
  logic id_mode = 1'b0;
  logic wr_open = 1'b0;
  logic wr_hv = 1'b0;
  int step = 0;
  int mem_ver = 0;
  // low only while strobe and select are both low; rises on the earlier rising edge
  wire wr_low = write_strobe_n | chip_sel_n;
  wire wr_end = write_strobe_n & chip_sel_n;
  wire drive = !chip_sel_n && !out_gate_n && write_strobe_n;
  function automatic logic [7:0] rd_byte(logic [20:0] a, logic [7:0] p, logic idm, logic hv);
    if (hv && !a[1]) return a[0] ? DEV_CODE : MFR_CODE;
    if (hv && !a[6] && !a[0]) return {7'h00, p[a[20:18]]};
    if (idm && a[7:0] == 8'h02) return {7'h00, p[a[20:18]]};
    if (idm) return a[0] ? DEV_CODE : MFR_CODE;
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // sequence state only; the array changes on a full program sequence
  task automatic command(logic [20:0] a, logic [7:0] d);
    if (step == 3) begin
      if (!prot[a[20:18]] || reset_hv) begin
        mem[a] = rd_byte(a, 8'h00, 1'b0, 1'b0) & d;
        mem_ver = mem_ver + 1;
      end
      step = 0;
    end else if (step == 0 && a[10:0] == 11'h555 && d == 8'haa) step = 1;
    else if (step == 1 && a[10:0] == 11'h2aa && d == 8'h55) step = 2;
    else if (step == 2 && a[10:0] == 11'h555 && d == 8'h90) begin
      id_mode = 1'b1;
      step = 0;
    end else if (step == 2 && a[10:0] == 11'h555 && d == 8'ha0) step = 3;
    else begin
      id_mode = 1'b0;
      step = 0;
    end
  endtask
  // mem_ver makes a program at an unchanged address show up on the pins
  always @(addr or prot or id_mode or id_pin_hv or mem_ver) begin
    q = rd_byte(addr, prot, id_mode, id_pin_hv);
  end
  // released bus shows the inverse of the last byte
  assign dq_out = drive ? q : ~last;
  always @(negedge drive) last = q;
  always @(negedge wr_low) begin
    a_lat = addr;
    wr_open = out_gate_n;
    wr_hv = id_pin_hv;
  end
  // protection pulse is framed by the strobe alone
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && id_pin_hv && out_gate_hv) prot[addr[20:18]] = 1'b1;
  end
  always @(posedge wr_end) begin
    if (wr_open && !wr_hv) command(a_lat, dq_in);
    wr_open = 1'b0;
  end
endmodule

// File: dv/tb.sv
// self-checking bench for the flash group-protect host
`timescale 1ns/100ps
module tb;
  import fsgp_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  fsgp_op_t cmd_op = FSGP_OP_READ;
  logic [20:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic unprotect_req = 1'b0;
  logic cmd_ready, rsp_valid, rsp_protected, flash_dq_oe_n;
  logic flash_chip_sel_n, flash_out_gate_n, flash_write_strobe_n;
  logic flash_id_pin_hv, flash_out_gate_hv, flash_reset_hv;
  logic [7:0] rsp_data, flash_dq_out, dev_q, got, pmask, d;
  logic [20:0] flash_addr, a;
  wire [7:0] bus = flash_dq_oe_n ? dev_q : flash_dq_out;
  logic [31:0] seed = 32'h0eca24d2;
  int mismatches = 0;
  int cmp_count = 0;
  always #25 clock = ~clock;
  fsgp_host #(.PROT_PULSE_CYC(4)) i_fsgp_host (
    .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .unprotect_req(unprotect_req),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_protected(rsp_protected), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(bus), .flash_chip_sel_n(flash_chip_sel_n),
    .flash_out_gate_n(flash_out_gate_n), .flash_write_strobe_n(flash_write_strobe_n),
    .flash_id_pin_hv(flash_id_pin_hv), .flash_out_gate_hv(flash_out_gate_hv),
    .flash_reset_hv(flash_reset_hv));
  fsgp_flash_model i_fsgp_flash_model (
    .addr(flash_addr), .dq_in(bus), .dq_out(dev_q), .chip_sel_n(flash_chip_sel_n),
    .out_gate_n(flash_out_gate_n), .write_strobe_n(flash_write_strobe_n),
    .id_pin_hv(flash_id_pin_hv), .out_gate_hv(flash_out_gate_hv), .reset_hv(flash_reset_hv));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] exp_byte(logic p, logic u, logic [7:0] dt);
    return (p && !u) ? 8'hff : dt;
  endfunction
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(logic want_rsp);
    int n;
    n = 0;
    while ((want_rsp ? rsp_valid : cmd_ready) !== 1'b1 && n < 400) begin
      @(posedge clock);
      #2;
      n++;
    end
    if ((want_rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic op(fsgp_op_t o, logic [20:0] ad, logic [7:0] dt);
    wait_for(1'b0);
    cmd_op = o;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_valid = 1'b1;
    @(posedge clock);
    #2;
    cmd_valid = 1'b0;
    if (o == FSGP_OP_READ || o == FSGP_OP_VERIFY) begin
      wait_for(1'b1);
      got = rsp_data;
      check({7'h00, rsp_protected}, {7'h00, got[0]});
    end
  endtask
  task automatic seq3(logic [7:0] second, logic [7:0] third);
    op(FSGP_OP_WRITE, 21'h000555, 8'haa);
    op(FSGP_OP_WRITE, 21'h0002aa, second);
    op(FSGP_OP_WRITE, 21'h000555, third);
  endtask
  task automatic prog_read(logic [20:0] ad, logic [7:0] dt);
    seq3(8'h55, 8'ha0);
    op(FSGP_OP_WRITE, ad, dt);
    op(FSGP_OP_READ, ad, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    #2;
    reset = 1'b0;
    for (int g = 0; g < 8; g++) begin
      op(FSGP_OP_VERIFY, {g[2:0], 18'h0}, 8'h00);
      check(got, 8'h00);
    end
    seed = xs(seed);
    pmask = (seed[7:0] | 8'h81) & 8'hbd;
    for (int g = 0; g < 8; g++) begin
      seed = xs(seed);
      if (pmask[g]) op(FSGP_OP_PROTECT, {g[2:0], seed[17:0]}, 8'h00);
    end
    for (int g = 0; g < 8; g++) begin
      seed = xs(seed);
      op(FSGP_OP_VERIFY, {g[2:0], seed[17:0]}, 8'h00);
      check(got, {7'h00, pmask[g]});
    end
    for (int g = 0; g < 8; g++) begin
      seed = xs(seed);
      a = {g[2:0], 1'b0, seed[16:0]};
      d = seed[31:24];
      prog_read(a, d);
      check(got, exp_byte(pmask[g], 1'b0, d));
    end
    seq3(8'h55, 8'h90);
    for (int g = 0; g < 8; g++) begin
      op(FSGP_OP_READ, {g[2:0], 10'h0, 8'h02}, 8'h00);
      check(got, {7'h00, pmask[g]});
    end
    op(FSGP_OP_WRITE, 21'h000000, 8'hf0);
    unprotect_req = 1'b1;
    prog_read(21'h020123, 8'h5c);
    check(got, exp_byte(1'b1, 1'b1, 8'h5c));
    unprotect_req = 1'b0;
    prog_read(21'h020200, 8'h3a);
    check(got, exp_byte(1'b1, 1'b0, 8'h3a));
    op(FSGP_OP_WRITE, 21'h060400, 8'h12);
    seq3(8'h56, 8'ha0);
    op(FSGP_OP_WRITE, 21'h060400, 8'h34);
    op(FSGP_OP_READ, 21'h060400, 8'h00);
    check(got, 8'hff);
    conclude();
  end
endmodule
